// ### design/rvi_bank.v
// record information and identity register bank behind the spi port.
// assumes capture, record and nonvolatile store logic outside; their
// events arrive as one-cycle pulses synchronous to clock.
`timescale 1ns/1ps
`include "rvi_regs.vh"
module rvi_bank
#(
	parameter        TICK_CYCLES = `RVI_TICK_MS * `RVI_CLK_KHZ,
	parameter [15:0] BUILD_DAY_FIRMWARE_REV_VAL = 16'h0110,  // bcd day, bcd revision
	parameter [15:0] YR_MON_VAL  = 16'h0001,  // bcd year, bcd month
	parameter [15:0] MODEL_CODE  = 16'h0123,  // arbitrary value
	parameter [15:0] LOT_NUMBER  = 16'h0001   // arbitrary value
)
(
	input  wire        clock,             // system clock, 50 mhz
	input  wire        sys_rst,           // async reset, high
	input  wire        spi_cs_n,          // spi chip select, low
	input  wire        spi_sclk,          // spi clock
	input  wire        spi_din,           // spi data from host
	output wire        spi_dout,          // spi data to host
	input  wire        sync_pin,          // external capture trigger
	input  wire        capture_req,       // internal capture request
	output reg         capture_start,     // capture begins, pulse
	input  wire        records_cleared,   // user records cleared
	input  wire        record_store_full, // tenth record written
	input  wire        spec_rec_upd,      // new spectral record
	input  wire [1:0]  spec_rate,         // sample rate choice
	input  wire [1:0]  spec_window,       // window of that record
	input  wire [7:0]  spec_avgs,         // averages of that record
	input  wire [15:0] nv_user_word,      // stored user word
	output reg         user_word_save,    // store user_word, pulse
	output reg  [15:0] user_word,         // user word to store
	output reg         stat_load,         // flash to sram, pulse
	output reg         stat_store,        // sram to flash, pulse
	output reg         stat_clear,        // clear statistics, pulse
	output reg         selftest_en,       // sensor self test on
	output wire        sync_enable        // sync pin armed
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg  [31:0] tick_r;
	reg  [31:0] secs_r;
	reg  [31:0] stamp_r;
	reg  [15:0] wear_r;
	reg  [15:0] wear_nxt;
	reg  [15:0] spec_r;
	reg         sync_en_r;
	reg         sync_d_r;
	reg         nv_loaded_r;
	reg  [6:0]  rd_adr_r;
	reg  [15:0] rd_word_r;
	reg  [15:0] rd_nxt;
	wire [15:0] rx_word;
	wire        rx_vld;
	wire        wr;
	wire        wr_hi;
	wire [6:0]  adr;
	wire [6:0]  adr_w;
	wire [7:0]  dat;
	wire        aux_hi_wr;
	wire        aux_lo_wr;
	wire        sync_rise;
	wire        capture_go;

	// ----------------------------------------------------------------
	// spi port
	// ----------------------------------------------------------------
	rvi_spi_shift u_spi
	(
		.clock    (clock),
		.sys_rst  (sys_rst),
		.spi_cs_n (spi_cs_n),
		.spi_sclk (spi_sclk),
		.spi_din  (spi_din),
		.spi_dout (spi_dout),
		.tx_word  (rd_word_r),
		.rx_word  (rx_word),
		.rx_vld   (rx_vld)
	);

	assign wr    = rx_vld & rx_word[`RVI_SPI_WR_BIT];
	assign adr   = rx_word[`RVI_SPI_ADR_HI:`RVI_SPI_ADR_LO];
	assign adr_w = {adr[6:1], 1'b0};
	assign wr_hi = adr[0];
	assign dat   = rx_word[`RVI_SPI_DAT_HI:0];

	assign aux_hi_wr = wr & wr_hi & (adr_w == `RVI_ADR_AUX);
	assign aux_lo_wr = wr & ~wr_hi & (adr_w == `RVI_ADR_AUX);

	// ----------------------------------------------------------------
	// seconds counter and capture timestamp
	// ----------------------------------------------------------------
	// relative time only: counts from reset, no calendar
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tick_r <= 32'h00000000;
			secs_r <= 32'h00000000;
		end
		else if (tick_r == TICK_CYCLES - 1)
		begin
			tick_r <= 32'h00000000;
			secs_r <= secs_r + 32'h00000001;
		end
		else
			tick_r <= tick_r + 32'h00000001;
	end

	assign sync_enable = sync_en_r;
	assign sync_rise   = sync_pin & ~sync_d_r;
	assign capture_go  = capture_req | (sync_en_r & sync_rise);

	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync_d_r      <= 1'b0;
			capture_start <= 1'b0;
			stamp_r       <= 32'h00000000;
		end
		else
		begin
			sync_d_r      <= sync_pin;
			capture_start <= capture_go;
			if (capture_go)
				stamp_r <= secs_r;
		end
	end

	// ----------------------------------------------------------------
	// user word, restored from nonvolatile store after reset
	// ----------------------------------------------------------------
	// async reset can only load a constant, so the stored value is
	// taken on the first edge after release
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			nv_loaded_r    <= 1'b0;
			user_word      <= `RVI_RST_WORD;
			user_word_save <= 1'b0;
		end
		else
		begin
			user_word_save <= 1'b0;
			if (!nv_loaded_r)
			begin
				nv_loaded_r <= 1'b1;
				user_word   <= nv_user_word;
			end
			else if (wr && adr_w == `RVI_ADR_USER)
			begin
				if (wr_hi)
					user_word[15:8] <= dat;
				else
					user_word[7:0]  <= dat;
				user_word_save <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// record store wear counter
	// ----------------------------------------------------------------
	// both events in one cycle count twice, none is lost
	always @*
	begin
		wear_nxt = wear_r;
		if (records_cleared)
			wear_nxt = wear_nxt + `RVI_ONE16;
		if (record_store_full)
			wear_nxt = wear_nxt + `RVI_ONE16;
	end

	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			wear_r <= `RVI_RST_WORD;
		else
			wear_r <= wear_nxt;
	end

	// ----------------------------------------------------------------
	// auxiliary control
	// ----------------------------------------------------------------
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync_en_r   <= 1'b0;
			stat_load   <= 1'b0;
			stat_store  <= 1'b0;
			stat_clear  <= 1'b0;
			selftest_en <= 1'b0;
		end
		else
		begin
			// command bits pulse once per frame that writes a one
			stat_load  <= aux_hi_wr & dat[`RVI_AUX_ST_LOAD - 8];
			stat_store <= aux_hi_wr & dat[`RVI_AUX_ST_SAVE - 8];
			stat_clear <= aux_hi_wr & dat[`RVI_AUX_ST_CLR - 8];
			if (aux_hi_wr)
				sync_en_r <= dat[`RVI_AUX_SYNC_EN - 8];
			// off wins when both are written together
			if (aux_lo_wr && dat[`RVI_AUX_TEST_OFF])
				selftest_en <= 1'b0;
			else if (aux_lo_wr && dat[`RVI_AUX_TEST_ON])
				selftest_en <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// spectral record settings
	// ----------------------------------------------------------------
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			spec_r <= `RVI_RST_WORD;
		else if (spec_rec_upd)
			spec_r <= {spec_rate, spec_window,
			           `RVI_SPEC_PAD, spec_avgs};
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// a read frame names the register; the word goes out in the
	// next frame, so the mux output is registered every cycle
	always @*
	begin
		case (rd_adr_r)
			`RVI_ADR_TIME_LO: rd_nxt = stamp_r[15:0];
			`RVI_ADR_TIME_HI: rd_nxt = stamp_r[31:16];
			`RVI_ADR_BUILD_DAY_FIRMWARE_REV: rd_nxt = BUILD_DAY_FIRMWARE_REV_VAL;
			`RVI_ADR_YR_MON:  rd_nxt = YR_MON_VAL;
			`RVI_ADR_MODEL:   rd_nxt = MODEL_CODE;
			`RVI_ADR_LOT:     rd_nxt = LOT_NUMBER;
			`RVI_ADR_USER:    rd_nxt = user_word;
			`RVI_ADR_WEAR:    rd_nxt = wear_r;
			`RVI_ADR_AUX:
				rd_nxt = {3'h0, sync_en_r, 8'h0,
				          selftest_en, 3'h0};
			`RVI_ADR_SPEC:    rd_nxt = spec_r;
			default:          rd_nxt = `RVI_RST_WORD;
		endcase
	end

	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rd_adr_r  <= 7'h00;
			rd_word_r <= `RVI_RST_WORD;
		end
		else
		begin
			rd_word_r <= rd_nxt;
			if (rx_vld && !rx_word[`RVI_SPI_WR_BIT])
				rd_adr_r <= adr_w;
		end
	end

endmodule

// ### design/rvi_regs.vh
// register offsets, field positions, reset values and timing for the
// record info / identity register bank.
// assumes 16-bit spi frames: bit 15 write flag, bits 14:8 byte address.
`ifndef RVI_REGS_VH
`define RVI_REGS_VH

// ----------------------------------------------------------------
// byte addresses (low byte of each 16-bit register)
// ----------------------------------------------------------------
`define RVI_ADR_TIME_LO  7'h4c
`define RVI_ADR_TIME_HI  7'h4e
`define RVI_ADR_BUILD_DAY_FIRMWARE_REV  7'h52
`define RVI_ADR_YR_MON   7'h54
`define RVI_ADR_MODEL    7'h56
`define RVI_ADR_LOT      7'h58
`define RVI_ADR_USER     7'h5a
`define RVI_ADR_WEAR     7'h5c
`define RVI_ADR_AUX      7'h64
`define RVI_ADR_SPEC     7'h66

// ----------------------------------------------------------------
// spi frame layout
// ----------------------------------------------------------------
`define RVI_SPI_WR_BIT   15
`define RVI_SPI_ADR_HI   14
`define RVI_SPI_ADR_LO   8
`define RVI_SPI_DAT_HI   7
`define RVI_FRAME_BITS   5'h10
`define RVI_BIT_CNT_W    5

// ----------------------------------------------------------------
// auxiliary control bits
// ----------------------------------------------------------------
`define RVI_AUX_SYNC_EN  12
`define RVI_AUX_ST_LOAD  10
`define RVI_AUX_ST_SAVE  9
`define RVI_AUX_ST_CLR   8
`define RVI_AUX_TEST_ON  3
`define RVI_AUX_TEST_OFF 2

// ----------------------------------------------------------------
// values and timing
// ----------------------------------------------------------------
`define RVI_RST_WORD     16'h0000
`define RVI_RST_BYTE     8'h00
`define RVI_SPEC_PAD     4'h0
`define RVI_ONE16        16'h0001
`define RVI_TICK_MS      1000
`define RVI_CLK_KHZ      50000

`endif

// ### design/rvi_spi_shift.v
// spi mode 3 shifter: 16-bit frames in, 16-bit answer words out.
// assumes spi pins already synchronous to clock and sclk well below
// half of the clock rate.
`timescale 1ns/1ps
module rvi_spi_shift
(
	input  wire        clock,     // system clock
	input  wire        sys_rst,   // async reset, high
	input  wire        spi_cs_n,  // chip select, low active
	input  wire        spi_sclk,  // serial clock, idles high
	input  wire        spi_din,   // serial data in
	output wire        spi_dout,  // serial data out
	input  wire [15:0] tx_word,   // word sent in the next frame
	output reg  [15:0] rx_word,   // last complete frame
	output reg         rx_vld     // one cycle when rx_word is new
);
`include "rvi_regs.vh"

	reg                      sclk_d_r;
	reg                      cs_d_r;
	reg  [15:0]              rx_sh_r;
	reg  [15:0]              tx_sh_r;
	reg  [`RVI_BIT_CNT_W-1:0] cnt_r;
	wire                     rise;
	wire                     fall;
	wire                     start;

	assign rise     = ~spi_cs_n & spi_sclk & ~sclk_d_r;
	assign fall     = ~spi_cs_n & ~spi_sclk & sclk_d_r;
	assign start    = ~spi_cs_n & cs_d_r;
	assign spi_dout = tx_sh_r[15];

	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sclk_d_r <= 1'b1;
			cs_d_r   <= 1'b1;
			rx_sh_r  <= `RVI_RST_WORD;
			tx_sh_r  <= `RVI_RST_WORD;
			cnt_r    <= {`RVI_BIT_CNT_W{1'b0}};
			rx_word  <= `RVI_RST_WORD;
			rx_vld   <= 1'b0;
		end
		else
		begin
			sclk_d_r <= spi_sclk;
			cs_d_r   <= spi_cs_n;
			rx_vld   <= 1'b0;
			if (spi_cs_n)
				cnt_r <= {`RVI_BIT_CNT_W{1'b0}};
			if (start)
				tx_sh_r <= tx_word;
			// msb stands before the first falling edge, so skip it
			else if (fall && cnt_r != {`RVI_BIT_CNT_W{1'b0}})
				tx_sh_r <= {tx_sh_r[14:0], 1'b0};
			if (rise)
			begin
				rx_sh_r <= {rx_sh_r[14:0], spi_din};
				if (cnt_r == `RVI_FRAME_BITS - 5'h01)
				begin
					cnt_r   <= {`RVI_BIT_CNT_W{1'b0}};
					rx_word <= {rx_sh_r[14:0], spi_din};
					rx_vld  <= 1'b1;
				end
				else
					cnt_r <= cnt_r + 5'h01;
			end
		end
	end

endmodule

// ### bench/rvi_host.sv
// host model: spi mode 3 master, 16-bit frames, called by the bench.
// assumes clock is the device clock; inputs change 1 ns after edges.
`timescale 1ns/1ps
module rvi_host
(
	input  wire clock,    // device clock
	output reg  spi_cs_n, // chip select, low
	output reg  spi_sclk, // idles high
	output reg  spi_din,  // data to device
	input  wire spi_dout  // data from device
);
	initial
	begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b1;
		spi_din  = 1'b0;
	end
	task automatic tk(input integer n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// two clocks a phase: sclk runs at clock/4, below the clock/2 the device needs
	task automatic xfer(input [15:0] w, output [15:0] r);
		integer i;
		begin
			tk(1);
			spi_cs_n = 1'b0;
			for (i = 15; i >= 0; i = i - 1)
			begin
				tk(2);
				spi_sclk = 1'b0;
				spi_din  = w[i];
				tk(2);
				spi_sclk = 1'b1;
				r[i]     = spi_dout;
			end
			tk(2);
			spi_cs_n = 1'b1;
			spi_din  = ~spi_din; // released line keeps no stale bit
			tk(3);
		end
	endtask
endmodule

// ### bench/rvi_bank_properties.sv
// checker for capture and command outputs of the register bank.
// assumes bound into rvi_bank; sees its ports only.
`timescale 1ns/1ps
module rvi_bank_chk
(
	input logic clock,         // system clock
	input logic sys_rst,       // async reset, high
	input logic sync_pin,      // external trigger
	input logic capture_req,   // internal request
	input logic capture_start, // capture pulse
	input logic sync_enable,   // sync armed
	input logic stat_load,     // load pulse
	input logic stat_store,    // store pulse
	input logic stat_clear,    // clear pulse
	input logic selftest_en    // self test level
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_sync_edge;
		sync_enable && $rose(sync_pin);
	endsequence
	sequence s_once(sig);
		sig ##1 !sig;
	endsequence
	a_req_starts: assert property (capture_req |=> capture_start)
		else $error("capture not started by request");
	a_sync_starts: assert property (s_sync_edge |=> capture_start)
		else $error("armed sync edge did not start capture");
	a_sync_gate: assert property (!sync_enable && !capture_req
		|=> !capture_start) else $error("capture without cause");
	a_start_cause: assert property (capture_start |->
		$past(capture_req) || $past(sync_enable && sync_pin))
		else $error("capture start has no source");
	a_load_once: assert property (stat_load |-> s_once(stat_load))
		else $error("load pulse longer than one cycle");
	a_store_once: assert property (stat_store |-> s_once(stat_store))
		else $error("store pulse longer than one cycle");
	a_clear_once: assert property (stat_clear |-> s_once(stat_clear))
		else $error("clear pulse longer than one cycle");
	a_reset_idle: assert property ($fell(sys_rst) |-> !(stat_load
		|| stat_store || stat_clear || selftest_en || sync_enable))
		else $error("outputs active after reset");
endmodule
bind rvi_bank rvi_bank_chk u_chk (.clock, .sys_rst, .sync_pin, .capture_req,
	.capture_start, .sync_enable, .stat_load, .stat_store, .stat_clear,
	.selftest_en);

// ### bench/tb_rvi_bank.sv
// self-checking bench for the register bank, host model on spi.
// assumes tick shortened to 10 clocks; identity values arbitrary.
`timescale 1ns/1ps
module tb_rvi_bank;
	localparam [15:0] DAY = 16'h2107; // arbitrary
	localparam [15:0] YM  = 16'h2403; // arbitrary
	localparam [15:0] MDL = 16'h0a5a; // arbitrary
	localparam [15:0] LOT = 16'h0042; // arbitrary
	reg clock, sys_rst, sync_pin, capture_req, records_cleared;
	reg record_store_full, spec_rec_upd;
	reg [1:0] spec_rate, spec_window;
	reg [7:0] spec_avgs;
	reg [15:0] nv_user_word;
	wire spi_cs_n, spi_sclk, spi_din, spi_dout, capture_start;
	wire user_word_save, stat_load, stat_store, stat_clear;
	wire selftest_en, sync_enable;
	wire [15:0] user_word;
	integer err_total, checked, cyc, n_ld, n_st, n_cl, n_cap, n_sv;
	rvi_bank #(.TICK_CYCLES(10), .BUILD_DAY_FIRMWARE_REV_VAL(DAY), .YR_MON_VAL(YM),
		.MODEL_CODE(MDL), .LOT_NUMBER(LOT)) uut (.clock, .sys_rst,
		.spi_cs_n, .spi_sclk, .spi_din, .spi_dout, .sync_pin, .capture_req,
		.capture_start, .records_cleared, .record_store_full, .spec_rec_upd,
		.spec_rate, .spec_window, .spec_avgs, .nv_user_word, .user_word_save,
		.user_word, .stat_load, .stat_store, .stat_clear, .selftest_en,
		.sync_enable);
	rvi_host host (.clock, .spi_cs_n, .spi_sclk, .spi_din, .spi_dout);
	always #10 clock = ~clock;
	// counted on the falling edge, where every output has settled
	always @(negedge clock)
	begin
		cyc = cyc + 1;
		n_sv = n_sv + (user_word_save === 1'b1);
		n_ld = n_ld + (stat_load === 1'b1);
		n_st = n_st + (stat_store === 1'b1);
		n_cl = n_cl + (stat_clear === 1'b1);
		n_cap = n_cap + (capture_start === 1'b1);
		if (cyc == 12000)
		begin
			err_total = err_total + 1;
			report_and_stop;
		end
	end
	task report_and_stop;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input [15:0] exp, input [15:0] got, input string what);
		checked = checked + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task tk;
		@(posedge clock);
		#1;
	endtask
	task wr(input [6:0] a, input [7:0] d);
		reg [15:0] r;
		host.xfer({1'b1, a, d}, r);
	endtask
	task rd(input [6:0] a, input [15:0] exp, input string what);
		reg [15:0] r;
		host.xfer({1'b0, a, 8'h00}, r);
		host.xfer({1'b0, a, 8'h00}, r);
		chk(exp, r, what);
	endtask
	task restart;
		sys_rst = 1'b1;
		repeat (4) tk;
		sys_rst = 1'b0;
		tk;
		tk;
	endtask
	initial
	begin
		{clock, sync_pin, capture_req, records_cleared} = 4'h0;
		{record_store_full, spec_rec_upd} = 2'b00;
		{spec_rate, spec_window, spec_avgs} = 12'h9ff;
		nv_user_word = 16'ha5c3;
		{err_total, checked, cyc, n_ld, n_st, n_cl, n_cap, n_sv} = 0;
		restart;
		rd(7'h4e, 16'h0000, "time_hi");
		rd(7'h52, DAY, "build_day_firmware_rev");
		rd(7'h54, YM, "year_month");
		rd(7'h56, MDL, "model");
		rd(7'h58, LOT, "lot");
		rd(7'h5a, 16'ha5c3, "user_word");
		rd(7'h66, 16'h0000, "spec_reset");
		rd(7'h70, 16'h0000, "unmapped");
		wr(7'h54, 8'hff);
		rd(7'h54, YM, "year_month_ro");
		wr(7'h5a, 8'h12);
		wr(7'h5b, 8'h34);
		rd(7'h5a, 16'h3412, "user_word_rw");
		chk(16'h3412, user_word, "user_word_out");
		chk(16'h0002, n_sv[15:0], "user_saves");
		capture_req = 1'b1;
		tk;
		capture_req = 1'b0;
		sync_pin = 1'b1; // not armed yet: ignored
		tk;
		sync_pin = 1'b0;
		wr(7'h65, 8'h10);
		rd(7'h64, 16'h1000, "aux_sync");
		chk(16'h0001, {15'h0, sync_enable}, "sync_armed");
		sync_pin = 1'b1;
		tk;
		sync_pin = 1'b0;
		tk;
		chk(16'h0002, n_cap[15:0], "captures");
		// high byte rewrite keeps bit 12 set
		wr(7'h65, 8'h14);
		wr(7'h65, 8'h12);
		wr(7'h65, 8'h11);
		wr(7'h65, 8'h10);
		chk(16'h0001, n_ld[15:0], "loads");
		chk(16'h0001, n_st[15:0], "stores");
		chk(16'h0001, n_cl[15:0], "clears");
		wr(7'h64, 8'h08);
		rd(7'h64, 16'h1008, "aux_test_on");
		wr(7'h64, 8'h0c);
		chk(16'h0000, {15'h0, selftest_en}, "test_off");
		records_cleared = 1'b1;
		tk;
		record_store_full = 1'b1;
		tk;
		records_cleared = 1'b0;
		tk;
		record_store_full = 1'b0;
		rd(7'h5c, 16'h0004, "wear");
		spec_rec_upd = 1'b1;
		tk;
		spec_rec_upd = 1'b0;
		// read again after a spectral record update, which loads the settings
		rd(7'h66, 16'h90ff, "spec");
		nv_user_word = user_word;
		restart;
		rd(7'h5a, 16'h3412, "user_kept");
		rd(7'h64, 16'h0000, "aux_reset");
		repeat (203) tk;
		capture_req = 1'b1;
		tk;
		capture_req = 1'b0;
		// capture at edge 486 after release: 48 whole ticks of 10
		rd(7'h4c, 16'h0030, "time_lo");
		rd(7'h4e, 16'h0000, "time_hi");
		report_and_stop;
	end
endmodule
